// ===== twt_pkg.sv
package twt_pkg;

    // ****************************************
    // Register offsets and reset values
    // ****************************************
    localparam logic [7:0] OFS_OWN   = 8'h00;
    localparam logic [7:0] OFS_CTRL  = 8'h01;
    localparam logic [7:0] OFS_COND  = 8'h02;
    localparam logic [7:0] OFS_BUF   = 8'h03;
    localparam logic [7:0] OFS_ISTAT = 8'h04;
    localparam logic [7:0] OFS_IMASK = 8'h05;
    localparam logic [7:0] RST_OWN   = 8'h00;
    localparam logic [7:0] RST_BUF   = 8'h00;
    localparam logic [1:0] RST_IRQ   = 2'h0;

    // ****************************************
    // Control and interrupt field positions
    // ****************************************
    localparam int CB_FLAG  = 7;
    localparam int CB_ACKEN = 6;
    localparam int CB_START = 5;
    localparam int CB_STOP  = 4;
    localparam int CB_WCOL  = 3;
    localparam int CB_EN    = 2;
    localparam int CB_IE    = 0;
    localparam int IB_XFER  = 0;
    localparam int IB_WAKE  = 1;
    localparam int PRE_W    = 3;

    // ****************************************
    // Condition codes and bus constants
    // ****************************************
    localparam logic [7:0] CC_OWN_READ  = 8'ha8;
    localparam logic [7:0] CC_ARB_READ  = 8'hb0;
    localparam logic [7:0] CC_DATA_ACK  = 8'hb8;
    localparam logic [7:0] CC_DATA_NACK = 8'hc0;
    localparam logic [7:0] CC_LAST_ACK  = 8'hc8;
    localparam logic [7:0] CC_NONE      = 8'hf8;
    localparam logic [6:0] BROADCAST    = 7'h00;
    localparam logic       DIR_READ     = 1'b1;
    localparam logic [2:0] LAST_BIT     = 3'h7;

    // ****************************************
    // Types
    // ****************************************
    typedef struct packed {
        logic scl;
        logic sda;
    } twt_pin_in_t;

    typedef struct packed {
        logic sclOut;
        logic sclOe;
        logic sdaOut;
        logic sdaOe;
    } twt_pin_drv_t;

    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_AACK_WAIT, S_AACK, S_WAIT, S_TX, S_TACK
    } twt_state_t;

endpackage : twt_pkg

// ===== twt_target_tx.sv
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
module twt_target_tx (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 nrst,
    // Register port
    input  wire logic [7:0]           regAddr,
    input  wire logic [7:0]           regWdata,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    output logic [7:0]                regRdata,
    // Bus pins
    input  wire twt_pkg::twt_pin_in_t pinIn,
    output twt_pkg::twt_pin_drv_t     pinDrv,
    // System
    input  wire logic                 arbLost,
    input  wire logic                 sleepDeep,
    output logic                      wakeReq,
    output logic                      startLaunch,
    output logic                      irq
);

    // ****************************************
    // Pin synchronisers and bus events
    // ****************************************
    logic [1:0] sclSync_q;
    logic [1:0] sdaSync_q;
    logic       sclPrev_q;
    logic       sdaPrev_q;
    logic       sclRise;
    logic       sclFall;
    logic       busStart;
    logic       busStop;

    // Two flops per pin; only the second stage feeds any logic
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sclSync_q <= 2'h3;
            sdaSync_q <= 2'h3;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclSync_q <= {sclSync_q[0], pinIn.scl};
            sdaSync_q <= {sdaSync_q[0], pinIn.sda};
            sclPrev_q <= sclSync_q[1];
            sdaPrev_q <= sdaSync_q[1];
        end
    end

    // Edges and framing conditions
    assign sclRise  = sclSync_q[1] & ~sclPrev_q;
    assign sclFall  = ~sclSync_q[1] & sclPrev_q;
    assign busStart = sclSync_q[1] & sclPrev_q & sdaPrev_q & ~sdaSync_q[1];
    assign busStop  = sclSync_q[1] & sclPrev_q & ~sdaPrev_q & sdaSync_q[1];

    // ****************************************
    // Register state
    // ****************************************
    twt_pkg::twt_state_t state_q;
    logic [7:0] own_q;
    logic [7:0] buf_q;
    logic [7:0] code_q;
    logic [7:0] pendCode_q;
    logic [7:0] shift_q;
    logic [2:0] cnt_q;
    logic       flag_q;
    logic       ackEn_q;
    logic       startReq_q;
    logic       stopReq_q;
    logic       wcol_q;
    logic       en_q;
    logic       ie_q;
    logic       last_q;
    logic       ackSeen_q;
    logic       wake_q;
    logic       busBusy_q;
    logic       startQueued_q;
    logic       sdaOe_q;
    logic       sclOe_q;
    logic [1:0] istat_q;
    logic [1:0] imask_q;
    logic [7:0] rdata_q;

    // Decoded accesses and hardware events
    logic       ctrlWr;
    logic       flagClr;
    logic [7:0] addrByte;
    logic       addrDone;
    logic       addrHit;
    logic       flagSet;
    logic [7:0] nextCode;
    logic       leaveAddr;

    assign ctrlWr   = regWr && regAddr == twt_pkg::OFS_CTRL;
    assign flagClr  = ctrlWr && regWdata[twt_pkg::CB_FLAG];
    assign addrByte = {shift_q[6:0], sdaSync_q[1]};
    assign addrDone = state_q == twt_pkg::S_ADDR && sclRise
                      && cnt_q == twt_pkg::LAST_BIT;
    // Own or broadcast match, gated live by acknowledge enable
    assign addrHit  = en_q && ackEn_q
                      && (addrByte[7:1] == own_q[7:1]
                          || (addrByte[7:1] == twt_pkg::BROADCAST && own_q[0]));
    assign flagSet  = sclFall && (state_q == twt_pkg::S_AACK
                                  || state_q == twt_pkg::S_TACK);
    // Receiver reply picks the next code; a last byte acked is 0xC8
    assign nextCode = state_q == twt_pkg::S_AACK ? pendCode_q :
                      !ackSeen_q ? twt_pkg::CC_DATA_NACK :
                      last_q ? twt_pkg::CC_LAST_ACK :
                      twt_pkg::CC_DATA_ACK;
    assign leaveAddr = state_q == twt_pkg::S_WAIT && flagClr
                       && (code_q == twt_pkg::CC_DATA_NACK
                           || code_q == twt_pkg::CC_LAST_ACK);

    // ****************************************
    // Software registers
    // ****************************************
    // Own address and byte buffer
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            own_q <= twt_pkg::RST_OWN;
            buf_q <= twt_pkg::RST_BUF;
        end else begin
            if (regWr && regAddr == twt_pkg::OFS_OWN) begin
                own_q <= regWdata;
            end
            if (regWr && regAddr == twt_pkg::OFS_BUF && flag_q) begin
                buf_q <= regWdata;
            end else if (addrDone && !sleepDeep) begin
                buf_q <= addrByte;
            end
        end
    end

    // Control bits; hardware setting the flag beats a clear
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            flag_q     <= 1'b0;
            ackEn_q    <= 1'b0;
            startReq_q <= 1'b0;
            stopReq_q  <= 1'b0;
            wcol_q     <= 1'b0;
            en_q       <= 1'b0;
            ie_q       <= 1'b0;
        end else begin
            if (flagSet) begin
                flag_q <= 1'b1;
            end else if (flagClr) begin
                flag_q <= 1'b0;
            end
            if (ctrlWr) begin
                ackEn_q    <= regWdata[twt_pkg::CB_ACKEN];
                startReq_q <= regWdata[twt_pkg::CB_START];
                stopReq_q  <= regWdata[twt_pkg::CB_STOP];
                en_q       <= regWdata[twt_pkg::CB_EN];
                ie_q       <= regWdata[twt_pkg::CB_IE];
            end
            // Buffer write while the flag is low is a collision
            if (regWr && regAddr == twt_pkg::OFS_BUF && !flag_q) begin
                wcol_q <= 1'b1;
            end else if (regWr && regAddr == twt_pkg::OFS_BUF) begin
                wcol_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Transfer sequencer
    // ****************************************
    // Not addressed on stop, disable or the end of a 0xC0/0xC8 turn
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            state_q    <= twt_pkg::S_IDLE;
            shift_q    <= 8'h00;
            cnt_q      <= 3'h0;
            pendCode_q <= twt_pkg::CC_OWN_READ;
            code_q     <= twt_pkg::CC_NONE;
            last_q     <= 1'b0;
            ackSeen_q  <= 1'b0;
        end else if (!en_q || busStop) begin
            state_q <= twt_pkg::S_IDLE;
        end else if (busStart) begin
            state_q <= twt_pkg::S_ADDR;
            cnt_q   <= 3'h0;
        end else begin
            unique case (state_q)
                twt_pkg::S_IDLE: state_q <= twt_pkg::S_IDLE;
                twt_pkg::S_ADDR: begin
                    if (sclRise) begin
                        shift_q <= addrByte;
                        cnt_q   <= cnt_q + 3'h1;
                    end
                    if (addrDone) begin
                        // Write direction belongs to the receive side
                        if (addrHit && addrByte[0] == twt_pkg::DIR_READ) begin
                            state_q    <= twt_pkg::S_AACK_WAIT;
                            pendCode_q <= arbLost ? twt_pkg::CC_ARB_READ
                                                  : twt_pkg::CC_OWN_READ;
                        end else begin
                            state_q <= twt_pkg::S_IDLE;
                        end
                    end
                end
                twt_pkg::S_AACK_WAIT: begin
                    if (sclFall) begin
                        state_q <= twt_pkg::S_AACK;
                    end
                end
                twt_pkg::S_AACK, twt_pkg::S_TACK: begin
                    if (state_q == twt_pkg::S_TACK && sclRise) begin
                        ackSeen_q <= ~sdaSync_q[1];
                    end
                    if (flagSet) begin
                        state_q <= twt_pkg::S_WAIT;
                        code_q  <= nextCode;
                    end
                end
                twt_pkg::S_WAIT: begin
                    if (leaveAddr) begin
                        state_q <= twt_pkg::S_IDLE;
                    end else if (flagClr) begin
                        state_q <= twt_pkg::S_TX;
                        shift_q <= buf_q;
                        cnt_q   <= 3'h0;
                        last_q  <= ~regWdata[twt_pkg::CB_ACKEN];
                    end
                end
                twt_pkg::S_TX: begin
                    if (sclFall) begin
                        shift_q <= {shift_q[6:0], 1'b1};
                        cnt_q   <= cnt_q + 3'h1;
                        if (cnt_q == twt_pkg::LAST_BIT) begin
                            state_q <= twt_pkg::S_TACK;
                        end
                    end
                    if (!ackEn_q) begin
                        last_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Code is frozen while the flag is low; it reads 0xF8 then
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            sdaOe_q <= 1'b0;
            sclOe_q <= 1'b0;
        end else begin
            sdaOe_q <= (state_q == twt_pkg::S_AACK)
                       || (state_q == twt_pkg::S_TX && !shift_q[7]);
            // Hold the clock low while software owns the turn
            sclOe_q <= en_q && (flag_q || flagSet);
        end
    end

    // ****************************************
    // Wake, queued start and interrupt
    // ****************************************
    // Wake request stays until software clears the flag
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            wake_q        <= 1'b0;
            busBusy_q     <= 1'b0;
            startQueued_q <= 1'b0;
        end else begin
            if (addrDone && addrHit && sleepDeep) begin
                wake_q <= 1'b1;
            end else if (flagClr) begin
                wake_q <= 1'b0;
            end
            if (busStart) begin
                busBusy_q <= 1'b1;
            end else if (busStop) begin
                busBusy_q <= 1'b0;
            end
            // The start request travels in the same write that clears the flag
            if (leaveAddr && regWdata[twt_pkg::CB_START]) begin
                startQueued_q <= 1'b1;
            end else if (!busBusy_q) begin
                startQueued_q <= 1'b0;
            end
        end
    end

    // Sticky events, set wins over a write-one clear
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            istat_q <= twt_pkg::RST_IRQ;
            imask_q <= twt_pkg::RST_IRQ;
        end else begin
            if (regWr && regAddr == twt_pkg::OFS_IMASK) begin
                imask_q <= regWdata[1:0];
            end
            istat_q <= (istat_q & ~((regWr && regAddr == twt_pkg::OFS_ISTAT)
                                    ? regWdata[1:0] : 2'h0))
                       | {addrDone && addrHit && sleepDeep, flagSet};
        end
    end

    // ****************************************
    // Register read port
    // ****************************************
    // Prescaler field of the condition code always reads zero
    always_ff @(posedge clk_sys) begin
        if (!nrst) begin
            rdata_q <= 8'h00;
        end else if (regRd) begin
            unique case (regAddr)
                twt_pkg::OFS_OWN:   rdata_q <= own_q;
                twt_pkg::OFS_CTRL:  rdata_q <= {flag_q, ackEn_q, startReq_q, stopReq_q,
                                                wcol_q, en_q, 1'b0, ie_q};
                twt_pkg::OFS_COND:  rdata_q <= flag_q
                    ? {code_q[7:twt_pkg::PRE_W], 3'h0}
                    : twt_pkg::CC_NONE;
                twt_pkg::OFS_BUF:   rdata_q <= buf_q;
                twt_pkg::OFS_ISTAT: rdata_q <= {6'h00, istat_q};
                twt_pkg::OFS_IMASK: rdata_q <= {6'h00, imask_q};
                default:            rdata_q <= 8'h00;
            endcase
        end
    end

    // Outputs; open-drain lines only ever pull low
    assign regRdata       = rdata_q;
    assign pinDrv.sclOut  = 1'b0;
    assign pinDrv.sclOe   = sclOe_q;
    assign pinDrv.sdaOut  = 1'b0;
    assign pinDrv.sdaOe   = sdaOe_q;
    assign wakeReq        = wake_q;
    assign startLaunch    = startQueued_q && !busBusy_q;
    assign irq            = |(istat_q & imask_q);

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_read_hit;
        addrDone && addrHit && addrByte[0];
    endsequence
    sequence s_last_acked;
        state_q == twt_pkg::S_TACK && last_q && ackSeen_q && sclFall;
    endsequence
    property p_prescaler;
        @(posedge clk_sys) disable iff (!nrst)
        regRd && regAddr == twt_pkg::OFS_COND |=> regRdata[2:0] == 3'h0;
    endproperty
    a_prescaler: assert property (p_prescaler)
        else $error("prescaler bits not zero");
    property p_no_ack_en;
        @(posedge clk_sys) disable iff (!nrst)
        addrDone && !ackEn_q && !busStop |=> state_q == twt_pkg::S_IDLE;
    endproperty
    a_no_ack_en: assert property (p_no_ack_en)
        else $error("address taken with acknowledge off");
    property p_read_mode;
        @(posedge clk_sys) disable iff (!nrst)
        s_read_hit ##0 !busStop |=> state_q == twt_pkg::S_AACK_WAIT;
    endproperty
    a_read_mode: assert property (p_read_mode)
        else $error("read address did not enter transmit");
    property p_arb_code;
        @(posedge clk_sys) disable iff (!nrst)
        s_read_hit ##0 arbLost ##0 !busStop |=>
            pendCode_q == twt_pkg::CC_ARB_READ;
    endproperty
    a_arb_code: assert property (p_arb_code)
        else $error("lost arbitration code wrong");
    property p_flag_set;
        @(posedge clk_sys) disable iff (!nrst)
        flagSet |=> flag_q ##1 sclOe_q;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag or stretch missing");
    property p_cond_none;
        @(posedge clk_sys) disable iff (!nrst)
        regRd && regAddr == twt_pkg::OFS_COND && !flag_q |=>
            regRdata == twt_pkg::CC_NONE;
    endproperty
    a_cond_none: assert property (p_cond_none)
        else $error("idle code not 0xF8");
    property p_last_ack;
        @(posedge clk_sys) disable iff (!nrst)
        s_last_acked ##0 en_q && !busStop && !busStart |=>
            code_q == twt_pkg::CC_LAST_ACK;
    endproperty
    a_last_ack: assert property (p_last_ack)
        else $error("last byte acked not 0xC8");
    property p_released;
        @(posedge clk_sys) disable iff (!nrst)
        state_q == twt_pkg::S_IDLE [*2] |=> !sdaOe_q;
    endproperty
    a_released: assert property (p_released)
        else $error("data line driven while not addressed");
    property p_leave;
        @(posedge clk_sys) disable iff (!nrst)
        leaveAddr && en_q && !busStart |=> state_q == twt_pkg::S_IDLE;
    endproperty
    a_leave: assert property (p_leave)
        else $error("did not leave after final code");

endmodule : twt_target_tx

// ===== twt_bus_ctrl_model.sv
`timescale 1ns/10ps
module twt_bus_ctrl_model (
    // Clock
    input  wire logic                  clk_sys,
    // Bus lines
    input  wire twt_pkg::twt_pin_drv_t pinDrv,
    output twt_pkg::twt_pin_in_t       pinIn
);
    // ****************************************
    // Open-drain lines
    // ****************************************
    logic sclLow = 1'b0;
    logic sdaLow = 1'b0;
    int   stuck  = 0;

    // Pull-ups: a line that nobody pulls reads high, never a stale level
    assign pinIn = {~(sclLow | pinDrv.sclOe), ~(sdaLow | pinDrv.sdaOe)};

    // ****************************************
    // Controller actions
    // ****************************************
    task automatic w(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : w

    // One clock pulse; the target may stretch low, so the wait is bounded
    task automatic pulse(output logic v);
        int k;
        k = 0;
        w(8);
        sclLow <= 1'b0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (pinIn.scl !== 1'b1 && k < 4000);
        if (k >= 4000) begin
            stuck++;
        end
        w(15);
        v = pinIn.sda;
        sclLow <= 1'b1;
    endtask : pulse

    // Data falls while the clock is high
    task automatic start();
        @(posedge clk_sys);
        sdaLow <= 1'b1;
        w(16);
        sclLow <= 1'b1;
        w(8);
    endtask : start

    // Data rises while the clock is high
    task automatic stop();
        @(posedge clk_sys);
        sdaLow <= 1'b1;
        w(8);
        sclLow <= 1'b0;
        w(16);
        sdaLow <= 1'b0;
        w(16);
    endtask : stop

    // Address byte out, most significant bit first, then the target's reply
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            @(posedge clk_sys);
            sdaLow <= ~d[i];
            pulse(v);
        end
        @(posedge clk_sys);
        sdaLow <= 1'b0;
        pulse(v);
        ack = ~v;
        w(8);
    endtask : wbyte

    // Data byte in; ackBit high pulls the reply low
    task automatic rbyte(input logic ackBit, output logic [7:0] d);
        logic v;
        @(posedge clk_sys);
        sdaLow <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            pulse(v);
            d[i] = v;
        end
        @(posedge clk_sys);
        sdaLow <= ackBit;
        pulse(v);
        @(posedge clk_sys);
        sdaLow <= 1'b0;
        w(8);
    endtask : rbyte
endmodule : twt_bus_ctrl_model

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
    // ****************************************
    // Signals and instances
    // ****************************************
    logic                  clk_sys   = 1'b0;
    logic                  nrst      = 1'b0;
    logic [7:0]            regAddr   = 8'h00;
    logic [7:0]            regWdata  = 8'h00;
    logic                  regWr     = 1'b0;
    logic                  regRd     = 1'b0;
    logic                  arbLost   = 1'b0;
    logic                  sleepDeep = 1'b0;
    logic [7:0]            regRdata;
    logic                  wakeReq;
    logic                  startLaunch;
    logic                  irq;
    logic [7:0]            b;
    logic                  ack;
    twt_pkg::twt_pin_in_t  pinIn;
    twt_pkg::twt_pin_drv_t pinDrv;
    int                    failures  = 0;
    int                    tests_run = 0;

    // Clock at 250 MHz
    always #2 clk_sys = ~clk_sys;

    twt_target_tx twt_target_tx_i (.clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .pinIn(pinIn), .pinDrv(pinDrv), .arbLost(arbLost), .sleepDeep(sleepDeep),
        .wakeReq(wakeReq), .startLaunch(startLaunch), .irq(irq));
    twt_bus_ctrl_model twt_bus_ctrl_model_i (.clk_sys(clk_sys), .pinDrv(pinDrv),
        .pinIn(pinIn));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk8

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk_sys);
        regWr    <= 1'b0;
    endtask : wr

    // Read data stand from the cycle after the strobe until the next read
    task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk_sys);
        regRd   <= 1'b0;
        #1;
        chk8(regRdata, exp, what);
    endtask : rdChk

    task automatic addrByte(input logic [6:0] a);
        twt_bus_ctrl_model_i.start();
        twt_bus_ctrl_model_i.wbyte({a, twt_pkg::DIR_READ}, ack);
        #1;
    endtask : addrByte

    // Final byte with a refusing receiver; the closing write may queue a start
    task automatic lastByte(input logic [7:0] d, input logic [7:0] ctl);
        logic seen;
        seen = 1'b0;
        wr(8'h03, d);
        wr(8'h01, 8'h84);
        twt_bus_ctrl_model_i.rbyte(1'b0, b);
        chk8(b, d, "last byte");
        rdChk(8'h02, twt_pkg::CC_DATA_NACK, "C0");
        wr(8'h01, ctl);
        // The launch lasts one cycle once the stop frees the bus, so watch all along
        fork
            twt_bus_ctrl_model_i.stop();
            repeat (60) begin
                @(negedge clk_sys);
                seen = seen | startLaunch;
            end
        join
        chk8({7'h00, seen}, {7'h00, ctl[twt_pkg::CB_START]}, "queued start");
    endtask : lastByte

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rdChk(8'h02, twt_pkg::CC_NONE, "idle code");
        rdChk(8'h00, twt_pkg::RST_OWN, "own reset");
        rdChk(8'h10, 8'h00, "unmapped");
        chk8({7'h00, irq}, 8'h00, "irq reset");
    endtask : t_reset

    task automatic t_read();
        wr(8'h00, {7'h2a, 1'b1});
        wr(8'h01, 8'h44);
        addrByte(7'h2a);
        chk8({7'h00, ack}, 8'h01, "own ack");
        chk8({7'h00, pinDrv.sclOe}, 8'h01, "stretch");
        rdChk(8'h02, twt_pkg::CC_OWN_READ, "A8");
        wr(8'h03, 8'ha5);
        wr(8'h01, 8'hc4);
        twt_bus_ctrl_model_i.rbyte(1'b1, b);
        chk8(b, 8'ha5, "byte 1");
        rdChk(8'h02, twt_pkg::CC_DATA_ACK, "B8");
        lastByte(8'h3c, 8'ha4);
        addrByte(7'h2a);
        chk8({7'h00, ack}, 8'h00, "ignored");
        twt_bus_ctrl_model_i.stop();
        wr(8'h01, 8'h44);
        addrByte(7'h2a);
        chk8({7'h00, ack}, 8'h01, "resumed");
        wr(8'h03, 8'h5a);
        wr(8'h01, 8'h84);
        twt_bus_ctrl_model_i.rbyte(1'b1, b);
        chk8(b, 8'h5a, "final");
        rdChk(8'h02, twt_pkg::CC_LAST_ACK, "C8");
        wr(8'h01, 8'h84);
        twt_bus_ctrl_model_i.rbyte(1'b1, b);
        chk8(b, 8'hff, "released");
        twt_bus_ctrl_model_i.stop();
    endtask : t_read

    task automatic t_bcast();
        wr(8'h01, 8'h44);
        addrByte(twt_pkg::BROADCAST);
        chk8({7'h00, ack}, 8'h01, "bcast on");
        lastByte(8'h96, 8'h84);
        wr(8'h00, {7'h2a, 1'b0});
        wr(8'h01, 8'h44);
        addrByte(twt_pkg::BROADCAST);
        chk8({7'h00, ack}, 8'h00, "bcast off");
        twt_bus_ctrl_model_i.stop();
    endtask : t_bcast

    task automatic t_arb();
        @(posedge clk_sys);
        arbLost <= 1'b1;
        addrByte(7'h2a);
        chk8({7'h00, ack}, 8'h01, "arb ack");
        rdChk(8'h02, twt_pkg::CC_ARB_READ, "B0");
        arbLost <= 1'b0;
        lastByte(8'h61, 8'h84);
    endtask : t_arb

    task automatic t_irq();
        rdChk(8'h04, 8'h01, "sticky");
        chk8({7'h00, irq}, 8'h00, "masked");
        wr(8'h05, 8'h01);
        @(negedge clk_sys);
        chk8({7'h00, irq}, 8'h01, "unmasked");
        wr(8'h04, 8'h01);
        @(negedge clk_sys);
        chk8({7'h00, irq}, 8'h00, "cleared");
        wr(8'h05, 8'h03);
    endtask : t_irq

    task automatic t_sleep();
        wr(8'h01, 8'h44);
        sleepDeep <= 1'b1;
        addrByte(7'h2a);
        chk8({7'h00, ack}, 8'h01, "sleep ack");
        chk8({7'h00, wakeReq}, 8'h01, "wake");
        repeat (40) @(posedge clk_sys);
        #1;
        chk8({7'h00, pinDrv.sclOe}, 8'h01, "held low");
        rdChk(8'h03, 8'h61, "buffer kept");
        rdChk(8'h04, 8'h03, "wake event");
        sleepDeep <= 1'b0;
        lastByte(8'h77, 8'h84);
        chk8({7'h00, wakeReq}, 8'h00, "awake");
    endtask : t_sleep

    // ****************************************
    // Run control
    // ****************************************
    task automatic tally_and_finish();
        failures += twt_bus_ctrl_model_i.stuck;
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    // Main sequence; pins stay idle a few cycles after reset
    initial begin
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_reset();
        t_read();
        t_bcast();
        t_arb();
        t_irq();
        t_sleep();
        tally_and_finish();
    end

    // Watchdog well beyond the expected run of some four thousand cycles
    initial begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        $display("ERROR t=%0t watchdog expired", $time);
        tally_and_finish();
    end
endmodule : tb_top
